// *** verification/dqwl_host_model.sv ***
// Host end of the single-wire line, with the line pull-up.
// Assumes the same clock as the device and a one-cycle break request.
module dqwl_host_model (
  input wire clk,
  input wire rst,
  input wire break_req,
  input wire hold_low,
  input wire dev_oe_n,
  output wire dq_line
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BREAK_CYCLES = 600200;
  int brk_cnt;
  // Break timer: low for a little over 3 ms
  always @(posedge clk) begin
    if (rst)
      brk_cnt <= 0;
    else if (break_req)
      brk_cnt <= BREAK_CYCLES;
    else if (brk_cnt > 0)
      brk_cnt <= brk_cnt - 1;
  end
  // Pull-up wins unless either side pulls low
  assign dq_line = !((brk_cnt > 0) || hold_low || !dev_oe_n);
endmodule // dqwl_host_model

// *** verification/dqwl_link_properties.sv ***
// Port-level checker for the single-wire link engine.
// Assumes MCLK at 200 MHz; bound onto every dqwl_link instance.
module dqwl_link_properties (
  // Clock and reset
  input wire MCLK,
  input wire SYS_RST,
  // Observed ports
  input wire DQ_IN,
  input wire DQ_OUT,
  input wire DQ_OE_N,
  input wire TWO_WIRE_CLOCK_PIN,
  input wire TWO_WIRE_DATA_PIN,
  input wire TX_BUSY,
  input wire RX_VALID,
  input wire OFFSET_CAL_START,
  input wire COMM_OFF
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  logic [31:0] low_cnt;
  logic [31:0] gap_cnt;
  logic [39:0] idle_cnt;
  logic oe_q;
  wire all_low = !TWO_WIRE_CLOCK_PIN && !TWO_WIRE_DATA_PIN && !DQ_IN;
  // Count drive-low time, time since last fall, and raw idle time
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      low_cnt <= 32'h0;
      gap_cnt <= 32'h0;
      idle_cnt <= 40'h0;
      oe_q <= 1'b1;
    end else begin
      oe_q <= DQ_OE_N;
      low_cnt <= DQ_OE_N ? 32'h0 : low_cnt + 32'h1;
      gap_cnt <= (oe_q && !DQ_OE_N) ? 32'h1 : gap_cnt + 32'h1;
      idle_cnt <= all_low ? idle_cnt + 40'h1 : 40'h0;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_start_hold_min: assert property ($rose(DQ_OE_N) |-> low_cnt >= 32'h0001_8608)
    else $error("drive low shorter than start hold");
  a_low_drive_max: assert property (!DQ_OE_N |-> low_cnt <= 32'h0009_0240)
    else $error("drive low longer than data end");
  a_bit_cycle_min: assert property ($fell(DQ_OE_N) && gap_cnt > 32'h0 |-> gap_cnt >= 32'h0009_26f8)
    else $error("bit cycle too short");
  // The first busy cycle of a new byte still counts the gap between bytes
  a_bit_cycle_max: assert property (TX_BUSY && !$rose(TX_BUSY) && DQ_OE_N |-> gap_cnt <= 32'h0012_5430)
    else $error("bit cycle too long");
  a_drive_when_busy: assert property (!DQ_OE_N |-> TX_BUSY)
    else $error("line driven outside a byte");
  a_data_pin_low: assert property (!DQ_OUT)
    else $error("open drain data not low");
  a_busoff_after_idle: assert property ($rose(COMM_OFF) |-> idle_cnt >= 40'h00_17d7_8400)
    else $error("bus off entered early");
  a_busoff_leaves: assert property (COMM_OFF && !all_low |-> ##[1:4] !COMM_OFF)
    else $error("bus off not left");
  a_cal_after_idle: assert property (OFFSET_CAL_START |-> idle_cnt >= 40'h00_bebc_2000)
    else $error("offset cal without idle time");
  a_cal_one_pulse: assert property (OFFSET_CAL_START |=> !OFFSET_CAL_START)
    else $error("offset cal pulse too long");
  a_rx_one_pulse: assert property (RX_VALID |=> !RX_VALID)
    else $error("receive pulse too long");
  // Main scenarios reached
  c_bit_start: cover property ($fell(DQ_OE_N));
  c_bit_release: cover property ($rose(DQ_OE_N));
  c_busy_high: cover property (TX_BUSY && DQ_OE_N);
endmodule // dqwl_link_properties

bind dqwl_link dqwl_link_properties u_props (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N),
  .TWO_WIRE_CLOCK_PIN(TWO_WIRE_CLOCK_PIN),
  .TWO_WIRE_DATA_PIN(TWO_WIRE_DATA_PIN), .TX_BUSY(TX_BUSY),
  .RX_VALID(RX_VALID), .OFFSET_CAL_START(OFFSET_CAL_START),
  .COMM_OFF(COMM_OFF));

// *** verification/dqwl_link_tb.sv ***
// Self-checking bench for the single-wire link engine.
// Assumes MCLK at 200 MHz; one byte start costs about 1M cycles.
module dqwl_link_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst, brk, hl, clkp, datp, tx_valid, slp;
  logic [7:0] tx_data;
  logic [12:0] cyc_t, start_t;
  wire dq_line, dq_out, dq_oe_n, tx_ready, tx_busy, rx_valid, rx_break;
  wire cal_start, comm_off;
  wire [7:0] rx_data;
  int mismatches, check_count, n;
  // ------------------------------------------------------------
  // Device, host and clock
  // ------------------------------------------------------------
  dqwl_link u_dut (.MCLK(mclk), .SYS_RST(rst), .DQ_IN(dq_line),
    .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .TWO_WIRE_CLOCK_PIN(clkp),
    .TWO_WIRE_DATA_PIN(datp), .DEVICE_BIT_CYCLE_TIME(cyc_t),
    .DEVICE_START_HOLD_TIME(start_t), .DEVICE_DATA_END_TIME(13'h07d0),
    .HOST_SAMPLE_TIME(13'h07d0), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_DATA(tx_data), .TX_BUSY(tx_busy), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_BREAK(rx_break), .SLEEP_ENTRY(slp),
    .SLEEP_ENTRIES_BEFORE_OFFSET_CAL(8'h01),
    .OFFSET_CAL_START(cal_start), .COMM_OFF(comm_off));
  dqwl_host_model u_host (.clk(mclk), .rst(rst), .break_req(brk),
    .hold_low(hl), .dev_oe_n(dq_oe_n), .dq_line(dq_line));
  initial begin
    mclk = 1'b0;
    forever
      #2.5 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_in(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic give_up(input string nm);
    mismatches++;
    $display("BAD %s expected event seen timeout", nm);
    report_and_stop();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_state();
    chk("oe_n", 32'h1, dq_oe_n);
    chk("busy", 32'h0, tx_busy);
    chk("ready", 32'h1, tx_ready);
    chk("comm_off", 32'h0, comm_off);
    chk("dq_out", 32'h0, dq_out);
  endtask
  task automatic t_fill_before_break();
    tx_valid = 1'b1;
    tx_data = 8'ha5;
    step(1);
    tx_data = 8'h3c;
    step(1);
    tx_data = 8'hff;
    chk("ready_full", 32'h0, tx_ready);
    step(5);
    chk("ready_held", 32'h0, tx_ready);
    tx_valid = 1'b0;
    step(2000);
    chk("no_send", 32'h1, dq_oe_n);
  endtask
  task automatic t_short_low();
    n = 0;
    hl = 1'b1;
    clkp = 1'b0;
    datp = 1'b0;
    for (int i = 0; i < 20000; i++) begin
      slp = (i % 5000 == 0);
      step(1);
      n += (rx_break === 1'b1) + (cal_start === 1'b1);
    end
    slp = 1'b0;
    chk("comm_off_early", 32'h0, comm_off);
    hl = 1'b0;
    clkp = 1'b1;
    datp = 1'b1;
    step(10);
    chk("no_break_no_cal", 32'h0, n);
  endtask
  task automatic t_break_and_send();
    brk = 1'b1;
    step(1);
    brk = 1'b0;
    n = 0;
    while (rx_break !== 1'b1) begin
      if (++n > 700000) give_up("rx_break");
      step(1);
    end
    n = 0;
    while (dq_oe_n !== 1'b0) begin
      if (++n > 260000) give_up("bit_start");
      step(1);
    end
    chk_in("recovery", 199000, 260000, n);
    chk("busy_on", 32'h1, tx_busy);
    chk("ready_drain", 32'h1, tx_ready);
    n = 0;
    while (dq_oe_n !== 1'b1) begin
      if (++n > 200000) give_up("start_end");
      step(1);
    end
    chk_in("start_hold", 99800, 100400, n);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mismatches = 0;
    check_count = 0;
    rst = 1'b1;
    brk = 1'b0;
    hl = 1'b0;
    clkp = 1'b1;
    datp = 1'b1;
    slp = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    cyc_t = 13'h1f40;
    start_t = 13'h0064;
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset_state();
    t_fill_before_break();
    t_short_low();
    t_break_and_send();
    report_and_stop();
  end
endmodule // dqwl_link_tb

// *** verilog/dqwl_defines.vh ***
// Constants for the single-wire link timing engine and idle detector.
// Assumes a 200 MHz system clock; bit and host times are kept in microseconds, idle times in milliseconds.
`ifndef DQWL_DEFINES_VH
`define DQWL_DEFINES_VH

// ----------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------
`define DQWL_CLK_PERIOD_NS 5
`define DQWL_US_NS 1000
`define DQWL_US_CYCLES (`DQWL_US_NS / `DQWL_CLK_PERIOD_NS)
`define DQWL_MS_US 1000

// ----------------------------------------------------------------------
// Device transmit bit timing limits, microseconds
// ----------------------------------------------------------------------
`define DQWL_CYC_MIN_US 13'h0bb8
`define DQWL_CYC_MAX_US 13'h1770
`define DQWL_START_MIN_US 13'h01f4
`define DQWL_START_MAX_US 13'h02ee
`define DQWL_DV_US 13'h05dc
`define DQWL_DEND_MAX_US 13'h0b86

// ----------------------------------------------------------------------
// Host side timing, microseconds
// ----------------------------------------------------------------------
`define DQWL_BREAK_US 13'h0bb8
`define DQWL_BREAK_REC_US 13'h03e8
`define DQWL_SAMPLE_MAX_US 13'h0bb7

// ----------------------------------------------------------------------
// Idle detection, milliseconds
// ----------------------------------------------------------------------
`define DQWL_COMM_OFF_MS 14'h07d0
`define DQWL_AUTOCAL_IDLE_MS 14'h3e80

`endif

// *** verilog/dqwl_link.v ***
// Device end of the open-drain single-wire link: bit timing for transmit,
// break and bit reception, bus-off detection and offset-cal trigger.
// Assumes the host pulls the line up, and that timing values come from
// nonvolatile storage held stable while a byte is in flight.
//
// How it works
// - Each transmitted bit lasts between 3 ms and 6 ms.
// - Each transmitted bit opens with a low start of 500 to 750 us.
// - Bit timing comes from configurable nonvolatile values.
// - No error-check code is added or checked on this link.
// - All three bus lines low for 2 s or more enters bus-off.
// - Any line going high leaves bus-off within 1 ms.
// - Offset cal starts after 16 s of low lines and enough sleeps.
// - Sleep entries are counted against a programmed threshold.
`include "dqwl_defines.vh"

module dqwl_link (
  // Clock and reset
  input wire MCLK,
  input wire SYS_RST,
  // Single-wire line, open drain
  input wire DQ_IN,
  output wire DQ_OUT,
  output reg DQ_OE_N,
  // Two-wire bus lines, observed only
  input wire TWO_WIRE_CLOCK_PIN,
  input wire TWO_WIRE_DATA_PIN,
  // Timing configuration, microseconds
  input wire [12:0] DEVICE_BIT_CYCLE_TIME,
  input wire [12:0] DEVICE_START_HOLD_TIME,
  input wire [12:0] DEVICE_DATA_END_TIME,
  input wire [12:0] HOST_SAMPLE_TIME,
  // Transmit byte stream
  input wire TX_VALID,
  output wire TX_READY,
  input wire [7:0] TX_DATA,
  output reg TX_BUSY,
  // Receive byte stream
  output reg RX_VALID,
  output reg [7:0] RX_DATA,
  output reg RX_BREAK,
  // Power management
  input wire SLEEP_ENTRY,
  input wire [7:0] SLEEP_ENTRIES_BEFORE_OFFSET_CAL,
  output reg OFFSET_CAL_START,
  output reg COMM_OFF
);

  localparam T_IDLE = 1'b0;
  localparam T_BIT = 1'b1;
  localparam R_WAIT_BREAK = 2'h0;
  localparam R_RECOVER = 2'h1;
  localparam R_READY = 2'h2;
  localparam R_BIT = 2'h3;

  // Limit a configured time to a legal window
  function [12:0] clamp;
    input [12:0] v;
    input [12:0] lo;
    input [12:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Synchronisers and time base
  // ----------------------------------------------------------------------
  reg [1:0] dq_sync_reg;
  reg [1:0] clk_sync_reg;
  reg [1:0] dat_sync_reg;
  reg dq_prev_reg;
  reg [7:0] us_div_reg;
  reg [9:0] ms_div_reg;
  wire dq_s = dq_sync_reg[1];
  wire us_tick = (us_div_reg == (`DQWL_US_CYCLES - 1));
  wire ms_tick = us_tick && (ms_div_reg == (`DQWL_MS_US - 1));
  wire dq_rise = dq_s && !dq_prev_reg;
  wire dq_fall = !dq_s && dq_prev_reg;

  // Two flops per pin, then a one-cycle-old copy for edges
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      dq_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h3;
      dat_sync_reg <= 2'h3;
      dq_prev_reg <= 1'b1;
    end else begin
      dq_sync_reg <= {dq_sync_reg[0], DQ_IN};
      clk_sync_reg <= {clk_sync_reg[0], TWO_WIRE_CLOCK_PIN};
      dat_sync_reg <= {dat_sync_reg[0], TWO_WIRE_DATA_PIN};
      dq_prev_reg <= dq_s;
    end
  end

  // Microsecond and millisecond enables
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      us_div_reg <= 8'h00;
      ms_div_reg <= 10'h000;
    end else begin
      us_div_reg <= us_tick ? 8'h00 : us_div_reg + 8'h01;
      if (us_tick)
        ms_div_reg <= ms_tick ? 10'h000 : ms_div_reg + 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Two-entry transmit buffer
  // ----------------------------------------------------------------------
  reg [7:0] buf0_reg;
  reg [7:0] buf1_reg;
  reg [1:0] buf_cnt_reg;
  wire buf_pop;
  assign TX_READY = (buf_cnt_reg != 2'h2);
  wire buf_push = TX_VALID && TX_READY;

  // Entry 0 is the head; a stalled engine lets the buffer fill
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      buf0_reg <= 8'h00;
      buf1_reg <= 8'h00;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (buf_pop) begin
        buf0_reg <= (buf_cnt_reg == 2'h2) ? buf1_reg : TX_DATA;
        if (buf_push && buf_cnt_reg == 2'h2)
          buf1_reg <= TX_DATA;
      end else if (buf_push) begin
        if (buf_cnt_reg == 2'h0)
          buf0_reg <= TX_DATA;
        else
          buf1_reg <= TX_DATA;
      end
      buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ----------------------------------------------------------------------
  // Transmit bit engine
  // ----------------------------------------------------------------------
  reg tx_state_reg;
  reg [2:0] tx_idx_reg;
  reg [7:0] tx_shift_reg;
  reg [12:0] tx_us_reg;
  reg [12:0] cyc_reg;
  reg [12:0] start_reg;
  reg [12:0] dend_reg;
  reg [1:0] rx_state_reg;
  // Start only on a tick so the first low lasts whole microseconds
  assign buf_pop = (tx_state_reg == T_IDLE) && (buf_cnt_reg != 2'h0) &&
                   us_tick && (rx_state_reg == R_READY) && dq_s;
  wire tx_low = (tx_us_reg < start_reg) ||
                ((tx_us_reg < dend_reg) && !tx_shift_reg[0]);

  // Sends each byte LSB first, with no check code appended
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      tx_state_reg <= T_IDLE;
      tx_idx_reg <= 3'h0;
      tx_shift_reg <= 8'hff;
      tx_us_reg <= 13'h0000;
      cyc_reg <= `DQWL_CYC_MIN_US;
      start_reg <= `DQWL_START_MIN_US;
      dend_reg <= `DQWL_DV_US;
      DQ_OE_N <= 1'b1;
      TX_BUSY <= 1'b0;
    end else begin
      case (tx_state_reg)
        T_IDLE: begin
          DQ_OE_N <= 1'b1;
          if (buf_pop) begin
            tx_state_reg <= T_BIT;
            tx_shift_reg <= buf0_reg;
            tx_idx_reg <= 3'h0;
            tx_us_reg <= 13'h0000;
            cyc_reg <= clamp(DEVICE_BIT_CYCLE_TIME, `DQWL_CYC_MIN_US,
                             `DQWL_CYC_MAX_US);
            start_reg <= clamp(DEVICE_START_HOLD_TIME, `DQWL_START_MIN_US,
                               `DQWL_START_MAX_US);
            dend_reg <= clamp(DEVICE_DATA_END_TIME, `DQWL_DV_US,
                              `DQWL_DEND_MAX_US);
            TX_BUSY <= 1'b1;
          end
        end
        T_BIT: begin
          DQ_OE_N <= !tx_low;
          if (us_tick) begin
            if (tx_us_reg == cyc_reg - 13'h0001) begin
              tx_us_reg <= 13'h0000;
              tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
              tx_idx_reg <= tx_idx_reg + 3'h1;
              if (tx_idx_reg == 3'h7) begin
                tx_state_reg <= T_IDLE;
                TX_BUSY <= 1'b0;
              end
            end else begin
              tx_us_reg <= tx_us_reg + 13'h0001;
            end
          end
        end
        default: tx_state_reg <= T_IDLE;
      endcase
    end
  end

  // Open drain: the pin only ever pulls low
  assign DQ_OUT = 1'b0;

  // ----------------------------------------------------------------------
  // Receive: break, recovery and bit sampling
  // ----------------------------------------------------------------------
  reg [12:0] low_us_reg;
  reg [12:0] high_us_reg;
  reg [12:0] rx_us_reg;
  reg [2:0] rx_cnt_reg;
  reg [7:0] rx_shift_reg;
  reg rx_done_reg;
  wire [12:0] samp = clamp(HOST_SAMPLE_TIME, `DQWL_DV_US,
                           `DQWL_SAMPLE_MAX_US);

  // Break is recognised at the rising edge that ends a long low
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      rx_state_reg <= R_WAIT_BREAK;
      low_us_reg <= 13'h0000;
      high_us_reg <= 13'h0000;
      rx_us_reg <= 13'h0000;
      rx_cnt_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_done_reg <= 1'b0;
      RX_VALID <= 1'b0;
      RX_DATA <= 8'h00;
      RX_BREAK <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      RX_BREAK <= 1'b0;
      if (dq_s)
        low_us_reg <= 13'h0000;
      else if (us_tick && low_us_reg != 13'h1fff)
        low_us_reg <= low_us_reg + 13'h0001;
      if (!dq_s)
        high_us_reg <= 13'h0000;
      else if (us_tick && high_us_reg != 13'h1fff)
        high_us_reg <= high_us_reg + 13'h0001;
      if (TX_BUSY) begin
        rx_state_reg <= R_READY;
      end else if (dq_rise && low_us_reg >= `DQWL_BREAK_US) begin
        rx_state_reg <= R_RECOVER;
        rx_cnt_reg <= 3'h0;
        RX_BREAK <= 1'b1;
      end else begin
        case (rx_state_reg)
          R_WAIT_BREAK: rx_state_reg <= R_WAIT_BREAK;
          R_RECOVER: begin
            if (dq_fall)
              rx_state_reg <= R_WAIT_BREAK;
            else if (high_us_reg >= `DQWL_BREAK_REC_US)
              rx_state_reg <= R_READY;
          end
          R_READY: begin
            if (dq_fall) begin
              rx_state_reg <= R_BIT;
              rx_us_reg <= 13'h0000;
              rx_done_reg <= 1'b0;
            end
          end
          R_BIT: begin
            if (us_tick)
              rx_us_reg <= rx_us_reg + 13'h0001;
            if (!rx_done_reg && us_tick && rx_us_reg == samp) begin
              rx_done_reg <= 1'b1;
              rx_shift_reg <= {dq_s, rx_shift_reg[7:1]};
              rx_cnt_reg <= rx_cnt_reg + 3'h1;
              if (rx_cnt_reg == 3'h7) begin
                RX_VALID <= 1'b1;
                RX_DATA <= {dq_s, rx_shift_reg[7:1]};
              end
            end
            if (dq_rise && rx_done_reg)
              rx_state_reg <= R_READY;
          end
          default: rx_state_reg <= R_WAIT_BREAK;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus-off and offset calibration trigger
  // ----------------------------------------------------------------------
  reg [13:0] idle_ms_reg;
  reg [7:0] sleep_cnt_reg;
  reg cal_done_reg;
  wire all_low = !dq_s && !clk_sync_reg[1] && !dat_sync_reg[1];
  wire cal_fire = !cal_done_reg && (idle_ms_reg >= `DQWL_AUTOCAL_IDLE_MS) &&
                  (sleep_cnt_reg >= SLEEP_ENTRIES_BEFORE_OFFSET_CAL);

  // Idle time counts while all lines are low; any high clears at once
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      idle_ms_reg <= 14'h0000;
      COMM_OFF <= 1'b0;
      cal_done_reg <= 1'b0;
      OFFSET_CAL_START <= 1'b0;
      sleep_cnt_reg <= 8'h00;
    end else begin
      OFFSET_CAL_START <= cal_fire;
      if (!all_low) begin
        idle_ms_reg <= 14'h0000;
        COMM_OFF <= 1'b0;
        cal_done_reg <= 1'b0;
      end else begin
        if (ms_tick && idle_ms_reg != 14'h3fff)
          idle_ms_reg <= idle_ms_reg + 14'h0001;
        if (idle_ms_reg >= `DQWL_COMM_OFF_MS)
          COMM_OFF <= 1'b1;
        if (cal_fire)
          cal_done_reg <= 1'b1;
      end
      // Restart the sleep count after a calibration; entries still count
      if (cal_fire)
        sleep_cnt_reg <= {7'h00, SLEEP_ENTRY};
      else if (SLEEP_ENTRY && sleep_cnt_reg != 8'hff)
        sleep_cnt_reg <= sleep_cnt_reg + 8'h01;
    end
  end

endmodule // dqwl_link
